/* rtl/bk2r_pkg.sv */
// Purpose: Constants for the second buck mode and enable register set
// Assumes: 8-bit register port fed by the serial host bus back end
// Notes: All registers reset to zero
// Overview of operation
// - Mode bit 7 selects low loop bandwidth
// - Mode bit 6 forces discontinuous conduction
// - Mode bit 5 lets pin three drive fast
// - Mode bit 4 forces PWM operation
// - Mode bit 3 high fixes peak current
// - Current bit 7 bypasses the lookup table
// - Voltage is 0.50V plus code times step
// - Mask bit n selects control pin n
// - Enable is OR of selected pins
// - Mask acts only for sequencing 111, enable 10
// - Sequencing 111 hands control after boot completes
// - Enable field: off, on, pins, reserved
package bk2r_pkg;
  // Register offsets
  localparam logic [7:0] OFF_MODE = 8'h3E;
  localparam logic [7:0] OFF_CUR = 8'h3F;
  localparam logic [7:0] OFF_VOLT = 8'h40;
  localparam logic [7:0] OFF_MASK = 8'h41;
  // Implemented bits per register
  localparam logic [7:0] MODE_WMASK = 8'hF8;
  localparam logic [7:0] CUR_WMASK = 8'h8F;
  localparam logic [7:0] VOLT_WMASK = 8'h3F;
  localparam logic [7:0] MASK_WMASK = 8'hFF;
  // Reset value of every register
  localparam logic [7:0] REG_RST = 8'h00;
  // Mode register field positions
  localparam int unsigned B_LOW_BW = 7;
  localparam int unsigned B_FRC_DCM = 6;
  localparam int unsigned B_PIN_FAST = 5;
  localparam int unsigned B_FRC_PWM = 4;
  localparam int unsigned B_ADAPT_DIS = 3;
  // Current register fields
  localparam int unsigned B_TBL_BYP = 7;
  localparam int unsigned CUR_CODE_W = 4;
  // Voltage code width
  localparam int unsigned VOLT_CODE_W = 6;
  // Control pin feeding fast mode
  localparam int unsigned FAST_PIN = 3;
  // Number of control pins
  localparam int unsigned NUM_PINS = 8;
  // Sequencing and enable field codes
  localparam logic [2:0] SEQ_BY_FIELD = 3'h7;
  localparam logic [1:0] EN_OFF = 2'h0;
  localparam logic [1:0] EN_ON = 2'h1;
  localparam logic [1:0] EN_BY_PINS = 2'h2;
  localparam logic [1:0] EN_RSVD = 2'h3;
  // Level scaling
  localparam logic [8:0] CUR_STEP_MA = 9'h019;
  localparam logic [11:0] VOLT_BASE_MV = 12'h1F4;
  localparam logic [11:0] VOLT_STEP_MV = 12'h019;
  localparam int unsigned MA_W = 9;
  localparam int unsigned MV_W = 12;
endpackage : bk2r_pkg

/* rtl/bk2r_pin_sync.sv */
// Purpose: Three-stage synchroniser for the multipurpose control pins
// Assumes: Pins are asynchronous to clk_i
// Notes: A change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module bk2r_pin_sync
  import bk2r_pkg::*;
#(
  parameter int unsigned WIDTH = NUM_PINS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] stable_o
);
  // All synchroniser state
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } bk2r_sync_t;

  bk2r_sync_t st_r;
  bk2r_sync_t st_nxt;
  logic [WIDTH-1:0] agree;

  // Stage two and three agreement
  assign agree = ~(st_r.s2 ^ st_r.s3);

  // Shift chain; first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.stable = (agree & st_r.s3) | (~agree & st_r.stable);
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stable_o = st_r.stable;
endmodule : bk2r_pin_sync
`default_nettype wire

/* rtl/bk2r_level_decode.sv */
// Purpose: Turns current and voltage codes into milliamps and millivolts
// Assumes: Codes come from registers on the same clock
// Notes: Purely combinational; caller registers the results
`timescale 1ns/1ps
`default_nettype none
module bk2r_level_decode
  import bk2r_pkg::*;
#(
  parameter logic [MV_W-1:0] VSTEP_MV = VOLT_STEP_MV
) (
  input wire logic [CUR_CODE_W-1:0] cur_code_i,
  input wire logic [VOLT_CODE_W-1:0] volt_code_i,
  output logic [MA_W-1:0] peak_ma_o,
  output logic [MV_W-1:0] target_mv_o
);
  // Linear current scale in fixed steps
  assign peak_ma_o = MA_W'(MA_W'(cur_code_i) * CUR_STEP_MA);
  // Linear voltage scale from the base level
  assign target_mv_o = MV_W'(VOLT_BASE_MV + MV_W'(volt_code_i) * VSTEP_MV);
endmodule : bk2r_level_decode
`default_nettype wire

/* rtl/bk2r_regs.sv */
// Purpose: Mode, current, voltage and pin mask registers of buck two
// Assumes: Host bus back end gives one-cycle read and write strobes
// Notes: Sequencing and enable fields arrive from their own register
`timescale 1ns/1ps
`default_nettype none
module bk2r_regs
  import bk2r_pkg::*;
#(
  parameter logic [MV_W-1:0] VSTEP_MV = VOLT_STEP_MV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  // Enable sources
  input wire logic [2:0] sequencing_sel_i,
  input wire logic [1:0] enable_sel_i,
  input wire logic boot_done_i,
  input wire logic seq_stage_en_i,
  input wire logic [NUM_PINS-1:0] multipurpose_control_pin_i,
  // Regulator controls
  output logic low_bandwidth_sel_o,
  output logic force_discontinuous_o,
  output logic force_pwm_o,
  output logic fast_mode_o,
  output logic adaptive_peak_en_o,
  output logic current_table_bypass_o,
  output logic [CUR_CODE_W-1:0] peak_current_code_o,
  output logic [MA_W-1:0] peak_current_ma_o,
  output logic [VOLT_CODE_W-1:0] output_voltage_code_o,
  output logic [MV_W-1:0] target_mv_o,
  output logic regulator_en_o
);
  // Whole block state
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] cur;
    logic [7:0] volt;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic ack;
    logic fast;
    logic adapt;
    logic [MA_W-1:0] ma;
    logic [MV_W-1:0] mv;
    logic reg_en;
  } bk2r_state_t;

  bk2r_state_t st_r;
  bk2r_state_t st_nxt;
  // Synchronised pin levels
  logic [NUM_PINS-1:0] pin_lvl;
  // Decoded levels
  logic [MA_W-1:0] dec_ma;
  logic [MV_W-1:0] dec_mv;
  // Read data selection
  logic [7:0] rd_mux;
  // Pin-driven enable term
  logic pins_en;
  // Field decides the enable
  logic by_field;

  // Pins come from outside the clock domain
  bk2r_pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(multipurpose_control_pin_i),
    .stable_o(pin_lvl)
  );

  // Code to level scaling
  bk2r_level_decode #(
    .VSTEP_MV(VSTEP_MV)
  ) u_dec (
    .cur_code_i(st_r.cur[CUR_CODE_W-1:0]),
    .volt_code_i(st_r.volt[VOLT_CODE_W-1:0]),
    .peak_ma_o(dec_ma),
    .target_mv_o(dec_mv)
  );

  assign pins_en = |(st_r.mask & pin_lvl);

  assign by_field = (sequencing_sel_i == SEQ_BY_FIELD) && boot_done_i;

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr_i)
      OFF_MODE: rd_mux = st_r.mode;
      OFF_CUR: rd_mux = st_r.cur;
      OFF_VOLT: rd_mux = st_r.volt;
      OFF_MASK: rd_mux = st_r.mask;
      default: rd_mux = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Acknowledge every strobe next cycle
    st_nxt.ack = reg_wr_i | reg_rd_i;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFF_MODE: st_nxt.mode = reg_wdata_i & MODE_WMASK;
        OFF_CUR: st_nxt.cur = reg_wdata_i & CUR_WMASK;
        OFF_VOLT: st_nxt.volt = reg_wdata_i & VOLT_WMASK;
        OFF_MASK: st_nxt.mask = reg_wdata_i & MASK_WMASK;
        default: ;
      endcase
    end
    // Read data held until next read
    if (reg_rd_i) begin
      st_nxt.rdata = rd_mux;
    end
    st_nxt.fast = st_r.mode[B_PIN_FAST] & pin_lvl[FAST_PIN];
    st_nxt.adapt = ~st_r.mode[B_ADAPT_DIS];
    if (st_r.cur[B_TBL_BYP]) begin
      st_nxt.ma = dec_ma;
    end else begin
      st_nxt.ma = '0;
    end
    st_nxt.mv = dec_mv;
    if (by_field) begin
      unique case (enable_sel_i)
        EN_OFF: st_nxt.reg_en = 1'b0;
        EN_ON: st_nxt.reg_en = 1'b1;
        EN_BY_PINS: st_nxt.reg_en = pins_en;
        EN_RSVD: st_nxt.reg_en = 1'b0;
      endcase
    end else if (sequencing_sel_i == SEQ_BY_FIELD) begin
      // Boot not finished yet
      st_nxt.reg_en = 1'b0;
    end else begin
      // Other sequencing codes follow the sequencer
      st_nxt.reg_en = seq_stage_en_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign reg_rdata_o = st_r.rdata;
  assign reg_ack_o = st_r.ack;
  assign low_bandwidth_sel_o = st_r.mode[B_LOW_BW];
  assign force_discontinuous_o = st_r.mode[B_FRC_DCM];
  assign force_pwm_o = st_r.mode[B_FRC_PWM];
  assign fast_mode_o = st_r.fast;
  assign adaptive_peak_en_o = st_r.adapt;
  assign current_table_bypass_o = st_r.cur[B_TBL_BYP];
  assign peak_current_code_o = st_r.cur[CUR_CODE_W-1:0];
  assign peak_current_ma_o = st_r.ma;
  assign output_voltage_code_o = st_r.volt[VOLT_CODE_W-1:0];
  assign target_mv_o = st_r.mv;
  assign regulator_en_o = st_r.reg_en;

  // Write strobes per register
  logic wr_mode;
  logic wr_cur;
  logic wr_volt;
  assign wr_mode = reg_wr_i && (reg_addr_i == OFF_MODE);
  assign wr_cur = reg_wr_i && (reg_addr_i == OFF_CUR);
  assign wr_volt = reg_wr_i && (reg_addr_i == OFF_VOLT);

  // Bandwidth bit follows a mode write
  property p_low_bw;
    @(posedge clk_i) disable iff (rst_i)
    wr_mode |=> low_bandwidth_sel_o == $past(reg_wdata_i[B_LOW_BW]);
  endproperty
  a_low_bw: assert property (p_low_bw)
    else $error("bandwidth select not written");

  // Discontinuous bit follows a mode write
  property p_dcm;
    @(posedge clk_i) disable iff (rst_i)
    wr_mode |=> force_discontinuous_o == $past(reg_wdata_i[B_FRC_DCM]);
  endproperty
  a_dcm: assert property (p_dcm)
    else $error("forced discontinuous not written");

  // Fast mode needs both the bit and the pin
  property p_fast;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> fast_mode_o ==
      $past(st_r.mode[B_PIN_FAST] & pin_lvl[FAST_PIN]);
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast mode not gated by pin three");

  // PWM bit follows a mode write, output one cycle on
  property p_pwm;
    @(posedge clk_i) disable iff (rst_i)
    wr_mode |=> force_pwm_o == $past(reg_wdata_i[B_FRC_PWM]);
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("forced PWM not written");

  // Adaptive enable is inverse of the mode bit after a write
  property p_adapt;
    @(posedge clk_i) disable iff (rst_i)
    wr_mode ##1 !wr_mode |=>
      adaptive_peak_en_o == !$past(reg_wdata_i[B_ADAPT_DIS], 2);
  endproperty
  a_adapt: assert property (p_adapt)
    else $error("adaptive peak select wrong");

  // Current level zero unless table bypassed
  property p_cur;
    @(posedge clk_i) disable iff (rst_i)
    wr_cur ##1 !wr_cur |=> peak_current_ma_o ==
      ($past(reg_wdata_i[B_TBL_BYP], 2) ?
        MA_W'($past(reg_wdata_i[3:0], 2) * 9'h019) : 9'h000);
  endproperty
  a_cur: assert property (p_cur)
    else $error("peak current level wrong");

  // Voltage target from a written code
  property p_volt;
    @(posedge clk_i) disable iff (rst_i)
    wr_volt ##1 !wr_volt |=> target_mv_o == MV_W'(VOLT_BASE_MV
      + MV_W'($past(reg_wdata_i[5:0], 2)) * VSTEP_MV);
  endproperty
  a_volt: assert property (p_volt)
    else $error("voltage target wrong");

  // Pin mode output is OR of masked pins
  property p_pins;
    @(posedge clk_i) disable iff (rst_i)
    (by_field && enable_sel_i == EN_BY_PINS) |=>
      regulator_en_o == $past(|(st_r.mask & pin_lvl));
  endproperty
  a_pins: assert property (p_pins)
    else $error("pin enable not OR of mask");

  // Outside pin mode the mask has no effect
  property p_nomask;
    @(posedge clk_i) disable iff (rst_i)
    (by_field && enable_sel_i != EN_BY_PINS) |=>
      regulator_en_o == ($past(enable_sel_i) == EN_ON);
  endproperty
  a_nomask: assert property (p_nomask)
    else $error("mask affected enable");

  // Reserved bits of mode read back zero
  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == OFF_MODE) |=> reg_rdata_o[2:0] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");

  // Table bypass bit follows a current write
  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
    wr_cur |=> current_table_bypass_o == $past(reg_wdata_i[B_TBL_BYP]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("table bypass not written");

  // Reserved enable code keeps the regulator off
  property p_en_rsvd;
    @(posedge clk_i) disable iff (rst_i)
    (by_field && enable_sel_i == EN_RSVD) |=> !regulator_en_o;
  endproperty
  a_en_rsvd: assert property (p_en_rsvd)
    else $error("reserved enable code turned regulator on");

  // Field control waits for boot to finish
  property p_boot;
    @(posedge clk_i) disable iff (rst_i)
    (sequencing_sel_i == SEQ_BY_FIELD && !boot_done_i) |=> !regulator_en_o;
  endproperty
  a_boot: assert property (p_boot)
    else $error("regulator on before boot done");

  // Scenario coverage
  c_pin_en: cover property (@(posedge clk_i) disable iff (rst_i)
    by_field && enable_sel_i == EN_BY_PINS ##1 regulator_en_o);
  c_fast: cover property (@(posedge clk_i) disable iff (rst_i)
    fast_mode_o);
  c_bypass: cover property (@(posedge clk_i) disable iff (rst_i)
    current_table_bypass_o && peak_current_ma_o != 9'h000);
  c_read: cover property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == OFF_MASK);
endmodule : bk2r_regs
`default_nettype wire

/* verif/bk2r_host_pins.sv */
// Purpose: Host side model driving the multipurpose control pins
// Assumes: Pins are asynchronous to the block clock
// Notes: Levels move on the falling edge, away from sampling
`timescale 1ns/1ps
`default_nettype none
module bk2r_host_pins (
  input wire logic clk_i,
  input wire logic [7:0] level_i,
  output logic [7:0] pin_o
);
  // Known level from time zero
  initial pin_o = 8'h00;
  // Pins follow the requested level half a cycle later
  always @(negedge clk_i) begin
    pin_o <= level_i;
  end
endmodule : bk2r_host_pins
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the buck two register set
// Assumes: Strobe register port, control pins from a host model
// Notes: Read data checked against a queue of expected values
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bk2r_pkg::*;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, boot_done_i, seq_stage_en_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pin_lvl, pins;
  logic [2:0] sequencing_sel_i;
  logic [1:0] enable_sel_i;
  logic reg_ack_o, lbw, dcm, pwm, fast, adp, byp, ren;
  logic [3:0] ccode;
  logic [8:0] ma;
  logic [5:0] vcode;
  logic [11:0] mv;
  int mismatches, samples_checked;
  // Expected answers; bit 8 marks a read
  logic [8:0] exp_q[$];

  bk2r_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .sequencing_sel_i(sequencing_sel_i), .enable_sel_i(enable_sel_i),
    .boot_done_i(boot_done_i), .seq_stage_en_i(seq_stage_en_i),
    .multipurpose_control_pin_i(pins), .low_bandwidth_sel_o(lbw),
    .force_discontinuous_o(dcm), .force_pwm_o(pwm), .fast_mode_o(fast),
    .adaptive_peak_en_o(adp), .current_table_bypass_o(byp),
    .peak_current_code_o(ccode), .peak_current_ma_o(ma),
    .output_voltage_code_o(vcode), .target_mv_o(mv),
    .regulator_en_o(ren));

  // Far side: host driving the control pins
  bk2r_host_pins host (.clk_i(clk_i), .level_i(pin_lvl), .pin_o(pins));

  // Clock at 200 MHz
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  // One write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    exp_q.push_back(9'h000);
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // One read strobe with its expected data
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back({1'b1, e});
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd

  // Verdict and end of run
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Monitor: each ack retires the oldest note
  always @(negedge clk_i) begin
    if (reg_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected ack", 12'h000, 12'h001);
      end else if (exp_q[0][8]) begin
        chk("reg_rdata_o", {4'h0, exp_q[0][7:0]}, {4'h0, reg_rdata_o});
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
      end
    end
  end

  // Watchdog
  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  // Main sequence
  initial begin
    logic [7:0] m, c, v, k, p;
    logic [2:0] s;
    logic [1:0] e;
    logic b, st, xe;
    {reg_wr_i, reg_rd_i, boot_done_i, seq_stage_en_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, pin_lvl} = 24'h000000;
    sequencing_sel_i = 3'h0;
    enable_sel_i = 2'h0;
    mismatches = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(23828));
    rd(OFF_MODE, REG_RST);
    rd(OFF_CUR, REG_RST);
    rd(OFF_VOLT, REG_RST);
    rd(OFF_MASK, REG_RST);
    #1;
    chk("adaptive_peak_en_o", 12'h001, {11'h0, adp});
    chk("target_mv_o", VOLT_BASE_MV, mv);
    for (int i = 0; i < 24; i++) begin
      m = 8'($urandom);
      c = 8'($urandom);
      v = 8'($urandom);
      k = 8'($urandom);
      p = 8'($urandom);
      s = (i % 5 == 4) ? 3'h2 : SEQ_BY_FIELD;
      e = 2'(i);
      b = (i % 7 != 6);
      st = 1'($urandom);
      wr(OFF_MODE, m);
      wr(OFF_CUR, c);
      wr(OFF_VOLT, v);
      wr(OFF_MASK, k);
      wr(8'h42, 8'($urandom));
      rd(8'h42, 8'h00);
      rd(OFF_MODE, m & MODE_WMASK);
      rd(OFF_CUR, c & CUR_WMASK);
      rd(OFF_VOLT, v & VOLT_WMASK);
      rd(OFF_MASK, k);
      @(posedge clk_i);
      sequencing_sel_i <= s;
      enable_sel_i <= e;
      boot_done_i <= b;
      seq_stage_en_i <= st;
      pin_lvl <= p;
      repeat (8) @(posedge clk_i);
      #1;
      xe = (s == SEQ_BY_FIELD) ?
        (b && (e == EN_ON || (e == EN_BY_PINS && (|(k & p))))) : st;
      chk("low_bandwidth_sel_o", {11'h0, m[B_LOW_BW]}, {11'h0, lbw});
      chk("force_discontinuous_o", {11'h0, m[B_FRC_DCM]}, {11'h0, dcm});
      chk("fast_mode_o", {11'h0, m[B_PIN_FAST] & p[FAST_PIN]},
          {11'h0, fast});
      chk("force_pwm_o", {11'h0, m[B_FRC_PWM]}, {11'h0, pwm});
      chk("adaptive_peak_en_o", {11'h0, ~m[B_ADAPT_DIS]}, {11'h0, adp});
      chk("current_table_bypass_o", {11'h0, c[B_TBL_BYP]}, {11'h0, byp});
      chk("peak_current_code_o", {8'h0, c[3:0]}, {8'h0, ccode});
      chk("peak_current_ma_o", c[B_TBL_BYP] ? 12'(c[3:0] * CUR_STEP_MA) :
          12'h000, {3'h0, ma});
      chk("output_voltage_code_o", {6'h0, v[5:0]}, {6'h0, vcode});
      chk("target_mv_o", 12'(VOLT_BASE_MV + v[5:0] * VOLT_STEP_MV), mv);
      chk("regulator_en_o", {11'h0, xe}, {11'h0, ren});
    end
    repeat (4) @(posedge clk_i);
    chk("pending acks", 12'h000, 12'(exp_q.size()));
    final_report();
  end
endmodule : tb
`default_nettype wire
